// ===== gpm_top.sv
// gpio ports P0-P3 and A with pin multiplexing behind an apb slave
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/10ps
module gpm_top
   import gpm_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic protect_release,
   input wire logic [7:0] p0_pin_in,
   input wire logic [6:0] p1_pin_in,
   input wire logic [7:0] p2_pin_in,
   input wire logic [6:0] p3_pin_in,
   input wire logic [7:0] pa_pin_in,
   input wire logic [39:0] lcd_seg_in,
   input wire logic uart0_tx,
   input wire logic uart1_tx,
   input wire logic active_energy_pulse,
   input wire logic reactive_energy_pulse,
   input wire logic apparent_energy_pulse,
   output gpm_drv_t p0_drv_r,
   output gpm_drv_t p1_drv_r,
   output gpm_drv_t p2_drv_r,
   output gpm_drv_t p3_drv_r,
   output gpm_drv_t pa_drv_r,
   output logic [7:0] lcd_segment_pin_select_r,
   output logic uart0_rx_r,
   output logic uart1_rx_r,
   output logic low_voltage_sense_input_r,
   output logic [6:0] key_in_r,
   output logic ext_interrupt_zero_r,
   output logic ext_interrupt_one_r,
   output logic [2:0] timer_in_r,
   output logic infrared_tx_select_r
);
   // port state from the port modules
   logic [7:0] p0_data, p0_dir, p0_led, p0_sync, p0_rd;
   logic [6:0] p1_data, p1_dir, p1_led, p1_sync;
   logic [7:0] p1_rd;
   logic [7:0] p2_data, p2_dir, p2_led, p2_sync, p2_rd;
   logic [6:0] p3_data, p3_dir, p3_led, p3_sync;
   logic [7:0] p3_rd;
   logic [7:0] pa_data, pa_dir, pa_led, pa_sync, pa_rd;
   logic [7:0] p02_sel;
   logic [7:0] p3_sel;
   logic [6:0] key_sel_r;
   gpm_drv_t p0_nxt, p1_nxt, p2_nxt, p3_nxt, pa_nxt;

   // apb phase decode
   wire acc = psel & penable;
   wire wr_go = ce & acc & pready & pwrite;
   wire addr_ok = (paddr[11:10] == 2'b00) & (paddr[1:0] == 2'b00);
   wire [7:0] idx = paddr[9:2];

   // register hits
   wire hit_p0 = addr_ok & (idx == IDX_P0_DATA);
   wire hit_p1 = addr_ok & (idx == IDX_P1_DATA);
   wire hit_pa = addr_ok & (idx == IDX_PA_DATA);
   wire hit_pad = addr_ok & (idx == IDX_PA_DIR);
   wire hit_p2 = addr_ok & (idx == IDX_P2_DATA);
   wire hit_p0d = addr_ok & (idx == IDX_P0_DIR);
   wire hit_p1d = addr_ok & (idx == IDX_P1_DIR);
   wire hit_p2d = addr_ok & (idx == IDX_P2_DIR);
   wire hit_p3d = addr_ok & (idx == IDX_P3_DIR);
   wire hit_p0l = addr_ok & (idx == IDX_P0_LED);
   wire hit_p1l = addr_ok & (idx == IDX_P1_LED);
   wire hit_p3l = addr_ok & (idx == IDX_P3_LED);
   wire hit_key = addr_ok & (idx == IDX_KEY_SEL);
   wire hit_p3 = addr_ok & (idx == IDX_P3_DATA);
   wire hit_lcd = addr_ok & (idx == IDX_LCD_SEL);
   wire hit_p02 = addr_ok & (idx == IDX_P02_SEL);
   wire hit_p3s = addr_ok & (idx == IDX_P3_SEL);
   wire mapped = hit_p0 | hit_p1 | hit_pa | hit_pad | hit_p2 | hit_p0d |
      hit_p1d | hit_p2d | hit_p3d | hit_p0l | hit_p1l | hit_p3l |
      hit_key | hit_p3 | hit_lcd | hit_p02 | hit_p3s;

   // function masks of ports P0, A, P2 and P3
   wire [7:0] m0 = {{2{p02_sel[3]}}, {2{p02_sel[2]}},
      {2{p02_sel[1]}}, {2{p02_sel[0]}}};
   wire [7:0] ma = {{4{lcd_segment_pin_select_r[1]}},
      {4{lcd_segment_pin_select_r[0]}}};
   wire [7:0] f2 = {{2{~p02_sel[P02_PULSE_BIT]}},
      {2{~p02_sel[P02_LVD_SF_BIT]}},
      {2{~p02_sel[P02_UART0_BIT]}},
      {2{~p02_sel[P02_UART1_BIT]}}};
   wire [7:0] fout2 = {reactive_energy_pulse, active_energy_pulse,
      apparent_energy_pulse, 1'b0, 1'b0, uart0_tx, 1'b0, uart1_tx};
   wire [6:0] f3 = {p3_sel[6:2], 2'b00};

   // read data selection
   wire [7:0] rd8 =
      ({8{hit_p0}} & p0_rd) | ({8{hit_p1}} & p1_rd) |
      ({8{hit_pa}} & pa_rd) | ({8{hit_pad}} & pa_dir) |
      ({8{hit_p2}} & p2_rd) | ({8{hit_p0d}} & p0_dir) |
      ({8{hit_p1d}} & {1'b0, p1_dir}) | ({8{hit_p2d}} & p2_dir) |
      ({8{hit_p3d}} & {1'b0, p3_dir}) | ({8{hit_p0l}} & p0_led) |
      ({8{hit_p1l}} & {1'b0, p1_led}) | ({8{hit_p3l}} & {1'b0, p3_led}) |
      ({8{hit_key}} & {1'b0, key_sel_r}) | ({8{hit_p3}} & p3_rd) |
      ({8{hit_lcd}} & lcd_segment_pin_select_r) |
      ({8{hit_p02}} & p02_sel) | ({8{hit_p3s}} & p3_sel);

   // apb answer: one wait state, error on unmapped address
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else if (ce)
      begin
         pready <= acc & ~pready;
         pslverr <= acc & ~pready & ~mapped;
         if (acc && !pready)
            prdata <= mapped ? {24'h00_0000, rd8} : 32'h0000_0000;
      end
   end

   // keypad pin select, not write-protected
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         key_sel_r <= RST_KEY_SEL;
      else if (wr_go && hit_key)
         key_sel_r <= pwdata[6:0];
   end

   // write-protected mux registers
   gpm_wp_reg #(.RST(RST_LCD_SEL), .MASK(MASK_FULL)) u_lcd_sel (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .we(wr_go & hit_lcd),
      .release_ok(protect_release),
      .wdata(pwdata[7:0]),
      .q_r(lcd_segment_pin_select_r)
   );
   gpm_wp_reg #(.RST(RST_P02_SEL), .MASK(MASK_FULL)) u_p02_sel (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .we(wr_go & hit_p02),
      .release_ok(protect_release),
      .wdata(pwdata[7:0]),
      .q_r(p02_sel)
   );
   gpm_wp_reg #(.RST(RST_P3_SEL), .MASK(MASK_P3_SEL)) u_p3_sel (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .we(wr_go & hit_p3s),
      .release_ok(protect_release),
      .wdata(pwdata[7:0]),
      .q_r(p3_sel)
   );

   // the five ports
   gpm_port #(.W(WIDE_PORT_W), .HAS_LED(1'b1)) u_p0 (
      .pclk(pclk), .presetn(presetn), .ce(ce), .wdata(pwdata[7:0]),
      .we_data(wr_go & hit_p0), .we_dir(wr_go & hit_p0d),
      .we_led(wr_go & hit_p0l), .pin_in(p0_pin_in), .force_in(m0),
      .data_r(p0_data), .dir_r(p0_dir), .led_r(p0_led),
      .sync_r(p0_sync), .rd_data(p0_rd)
   );
   gpm_port #(.W(NARROW_PORT_W), .HAS_LED(1'b1)) u_p1 (
      .pclk(pclk), .presetn(presetn), .ce(ce), .wdata(pwdata[7:0]),
      .we_data(wr_go & hit_p1), .we_dir(wr_go & hit_p1d),
      .we_led(wr_go & hit_p1l), .pin_in(p1_pin_in), .force_in(key_sel_r),
      .data_r(p1_data), .dir_r(p1_dir), .led_r(p1_led),
      .sync_r(p1_sync), .rd_data(p1_rd)
   );
   gpm_port #(.W(WIDE_PORT_W), .HAS_LED(1'b0)) u_p2 (
      .pclk(pclk), .presetn(presetn), .ce(ce), .wdata(pwdata[7:0]),
      .we_data(wr_go & hit_p2), .we_dir(wr_go & hit_p2d),
      .we_led(1'b0), .pin_in(p2_pin_in), .force_in(f2),
      .data_r(p2_data), .dir_r(p2_dir), .led_r(p2_led),
      .sync_r(p2_sync), .rd_data(p2_rd)
   );
   gpm_port #(.W(NARROW_PORT_W), .HAS_LED(1'b1)) u_p3 (
      .pclk(pclk), .presetn(presetn), .ce(ce), .wdata(pwdata[7:0]),
      .we_data(wr_go & hit_p3), .we_dir(wr_go & hit_p3d),
      .we_led(wr_go & hit_p3l), .pin_in(p3_pin_in), .force_in(f3),
      .data_r(p3_data), .dir_r(p3_dir), .led_r(p3_led),
      .sync_r(p3_sync), .rd_data(p3_rd)
   );
   gpm_port #(.W(WIDE_PORT_W), .HAS_LED(1'b0)) u_pa (
      .pclk(pclk), .presetn(presetn), .ce(ce), .wdata(pwdata[7:0]),
      .we_data(wr_go & hit_pa), .we_dir(wr_go & hit_pad),
      .we_led(1'b0), .pin_in(pa_pin_in), .force_in(ma),
      .data_r(pa_data), .dir_r(pa_dir), .led_r(pa_led),
      .sync_r(pa_sync), .rd_data(pa_rd)
   );

   // P0: lcd segment pairs or gpio
   assign p0_nxt.out = (m0 & lcd_seg_in[39:32]) | (~m0 & p0_data);
   assign p0_nxt.oe = m0 | p0_dir;
   assign p0_nxt.led = ~m0 & p0_led;

   // P1: keypad enable overrides direction
   assign p1_nxt.out = {1'b0, p1_data};
   assign p1_nxt.oe = {1'b0, p1_dir & ~key_sel_r};
   assign p1_nxt.led = {1'b0, p1_led};

   // P2: uart, voltage sense and pulse functions or gpio
   assign p2_nxt.out = (f2 & fout2) | (~f2 & p2_data);
   assign p2_nxt.oe = (f2 & P2_FUNC_OE) | (~f2 & p2_dir);
   assign p2_nxt.led = 8'h00;

   // P3: interrupt and timer inputs or gpio
   assign p3_nxt.out = {1'b0, p3_data};
   assign p3_nxt.oe = {1'b0, p3_dir & ~f3};
   assign p3_nxt.led = {1'b0, p3_led};

   // port A: lcd segment nibbles or gpio
   assign pa_nxt.out = (ma & lcd_seg_in[7:0]) | (~ma & pa_data);
   assign pa_nxt.oe = ma | pa_dir;
   assign pa_nxt.led = 8'h00;

   // pad drive registers; all pins are inputs during reset, P2 function pins drive once it ends
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         p0_drv_r <= '0;
         p1_drv_r <= '0;
         p2_drv_r <= '0;
         p3_drv_r <= '0;
         pa_drv_r <= '0;
      end
      else if (ce)
      begin
         p0_drv_r <= p0_nxt;
         p1_drv_r <= p1_nxt;
         p2_drv_r <= p2_nxt;
         p3_drv_r <= p3_nxt;
         pa_drv_r <= pa_nxt;
      end
   end

   // peripheral inputs; a pin not given to its function reads high
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         uart1_rx_r <= 1'b1;
         uart0_rx_r <= 1'b1;
         low_voltage_sense_input_r <= 1'b1;
         key_in_r <= 7'h7F;
         ext_interrupt_zero_r <= 1'b1;
         ext_interrupt_one_r <= 1'b1;
         timer_in_r <= 3'h7;
      end
      else if (ce)
      begin
         uart1_rx_r <= p2_sync[1] | ~f2[1];
         uart0_rx_r <= p2_sync[3] | ~f2[3];
         low_voltage_sense_input_r <= p2_sync[4] | ~f2[4];
         key_in_r <= p1_sync | ~key_sel_r;
         ext_interrupt_zero_r <= p3_sync[2] | ~f3[2];
         ext_interrupt_one_r <= p3_sync[3] | ~f3[3];
         timer_in_r <= p3_sync[6:4] | ~f3[6:4];
      end
   end

   // infrared select is a stored bit of the port3 select register
   assign infrared_tx_select_r = p3_sel[P3_IRTX_BIT];

   // checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_gpio_dir;
      ce && (&p02_sel[7:4]) |=> p2_drv_r.oe == $past(p2_dir);
   endproperty
   a_gpio_dir: assert property (p_gpio_dir)
      else $error("P2 gpio enable does not follow direction");

   property p_lcd_pa;
      ce && lcd_segment_pin_select_r[0] |=>
         pa_drv_r.out[3:0] == $past(lcd_seg_in[3:0]) &&
         pa_drv_r.oe[3:0] == 4'hF;
   endproperty
   a_lcd_pa: assert property (p_lcd_pa)
      else $error("port A low nibble not driven by segments");

   property p_lcd_p0;
      ce && p02_sel[0] |=>
         p0_drv_r.out[1:0] == $past(lcd_seg_in[33:32]) &&
         p0_drv_r.led[1:0] == 2'b00;
   endproperty
   a_lcd_p0: assert property (p_lcd_p0)
      else $error("P0 pair not driven by segments");

   property p_uart1;
      ce && !p02_sel[P02_UART1_BIT] |=>
         p2_drv_r.out[0] == $past(uart1_tx) && p2_drv_r.oe[1:0] == 2'b01;
   endproperty
   a_uart1: assert property (p_uart1)
      else $error("uart1 pins not routed");

   property p_lvd_sf;
      ce && !p02_sel[P02_LVD_SF_BIT] |=>
         !p2_drv_r.oe[4] && p2_drv_r.out[5] == $past(apparent_energy_pulse);
   endproperty
   a_lvd_sf: assert property (p_lvd_sf)
      else $error("voltage sense or apparent pulse not routed");

   property p_pulse;
      ce && !p02_sel[P02_PULSE_BIT] |=>
         p2_drv_r.out[7:6] ==
         $past({reactive_energy_pulse, active_energy_pulse});
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("energy pulses not routed");

   property p_protect;
      !protect_release && wr_go |=> $stable(p02_sel) &&
         $stable(lcd_segment_pin_select_r) && $stable(p3_sel);
   endproperty
   a_protect: assert property (p_protect)
      else $error("protected register changed while locked");

   property p_key_force;
      ce && key_sel_r[0] |=> !p1_drv_r.oe[0];
   endproperty
   a_key_force: assert property (p_key_force)
      else $error("keypad pin not forced to input");

   property p_ext_interrupt_zero;
      ce && p3_sel[2] |=> ext_interrupt_zero_r == $past(p3_sync[2]) &&
         !p3_drv_r.oe[2];
   endproperty
   a_ext_interrupt_zero: assert property (p_ext_interrupt_zero)
      else $error("interrupt zero input not routed");

   property p_narrow_read;
      pready && (hit_p1 || hit_p3 || hit_key) |-> prdata[31:7] == 25'h0;
   endproperty
   a_narrow_read: assert property (p_narrow_read)
      else $error("reserved bit of narrow port read non-zero");

   property p_apb_answer;
      ce && acc && !pready |=> pready || !ce;
   endproperty
   a_apb_answer: assert property (p_apb_answer)
      else $error("apb answer not given after one wait cycle");

   c_lcd_write: cover property (wr_go && hit_lcd && protect_release);
   c_key_on: cover property (ce && key_sel_r != 7'h00);
   c_p2_gpio: cover property (ce && (&p02_sel[7:4]));
   c_unmapped: cover property (pready && pslverr);
endmodule : gpm_top

// ===== gpm_pkg.sv
// shared constants, field positions and carrier types of the gpio/pin-mux block
// Overview of operation
// - direction bit: 0 input, 1 output
// - lcd select bits give port pins to segments
// - low port0/2 select bits give P0 pairs segments
// - uart pairs on P2 when select bits zero
// - bit6 zero: voltage sense in, apparent pulse out
// - bit7 zero: active and reactive pulse outputs
// - three mux registers writable only when released
// - keypad bits give P1 pins to keyboard
// - port3 select bits give interrupt/timer inputs
// - led bit selects sinking led drive
// - P0, P2, A eight bits; P1, P3 seven
// - led drive only on P0, P1, P3
// - every pin individually input or output
// - keypad enable forces P1 pin input
package gpm_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_P0_DATA = 8'h80;
   localparam logic [7:0] IDX_P1_DATA = 8'h90;
   localparam logic [7:0] IDX_PA_DATA = 8'h93;
   localparam logic [7:0] IDX_PA_DIR = 8'h9B;
   localparam logic [7:0] IDX_P2_DATA = 8'hA0;
   localparam logic [7:0] IDX_P0_DIR = 8'hA1;
   localparam logic [7:0] IDX_P1_DIR = 8'hA2;
   localparam logic [7:0] IDX_P2_DIR = 8'hA3;
   localparam logic [7:0] IDX_P3_DIR = 8'hA4;
   localparam logic [7:0] IDX_P0_LED = 8'hA5;
   localparam logic [7:0] IDX_P1_LED = 8'hA6;
   localparam logic [7:0] IDX_P3_LED = 8'hA7;
   localparam logic [7:0] IDX_KEY_SEL = 8'hAD;
   localparam logic [7:0] IDX_P3_DATA = 8'hB0;
   localparam logic [7:0] IDX_LCD_SEL = 8'hB9;
   localparam logic [7:0] IDX_P02_SEL = 8'hBA;
   localparam logic [7:0] IDX_P3_SEL = 8'hBB;
   // values after reset
   localparam logic [7:0] RST_DATA = 8'h00;
   localparam logic [7:0] RST_DIR = 8'h00;
   localparam logic [7:0] RST_LED = 8'h00;
   localparam logic [7:0] RST_LCD_SEL = 8'h00;
   localparam logic [7:0] RST_P02_SEL = 8'h00;
   localparam logic [7:0] RST_P3_SEL = 8'h00;
   localparam logic [6:0] RST_KEY_SEL = 7'h00;
   // implemented bits of the mux registers
   localparam logic [7:0] MASK_FULL = 8'hFF;
   localparam logic [7:0] MASK_P3_SEL = 8'h7E;
   // field positions of the port0/2 and port3 select registers
   localparam int P02_UART1_BIT = 4;
   localparam int P02_UART0_BIT = 5;
   localparam int P02_LVD_SF_BIT = 6;
   localparam int P02_PULSE_BIT = 7;
   localparam int P3_IRTX_BIT = 1;
   // pins driven by P2 peripheral functions: tx1, tx0, sf, pf, qf
   localparam logic [7:0] P2_FUNC_OE = 8'hE5;
   // documented port widths
   localparam int WIDE_PORT_W = 8;
   localparam int NARROW_PORT_W = 7;
   // drive of one port's pads
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
      logic [7:0] led;
   } gpm_drv_t;
endpackage : gpm_pkg

// ===== gpm_wp_reg.sv
// write-protected 8-bit configuration register
`timescale 1ns/10ps
module gpm_wp_reg
   import gpm_pkg::*;
#(
   parameter logic [7:0] RST = 8'h00,
   parameter logic [7:0] MASK = 8'hFF
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic we,
   input wire logic release_ok,
   input wire logic [7:0] wdata,
   output logic [7:0] q_r
);
   // store only while protection is released
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         q_r <= RST & MASK;
      else if (ce && we && release_ok)
         q_r <= wdata & MASK;
   end
endmodule : gpm_wp_reg

// ===== gpm_port.sv
// one gpio port: data latch, direction, led drive and pin synchroniser
`timescale 1ns/10ps
module gpm_port
   import gpm_pkg::*;
#(
   parameter int W = 8,
   parameter bit HAS_LED = 1'b1
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic [7:0] wdata,
   input wire logic we_data,
   input wire logic we_dir,
   input wire logic we_led,
   input wire logic [W-1:0] pin_in,
   input wire logic [W-1:0] force_in,
   output logic [W-1:0] data_r,
   output logic [W-1:0] dir_r,
   output logic [W-1:0] led_r,
   output logic [W-1:0] sync_r,
   output logic [7:0] rd_data
);
   logic [W-1:0] meta_r;
   wire [W-1:0] eff_dir;
   wire [W-1:0] rd_bits;

   // refuse widths the byte registers cannot hold
   if (W < 1 || W > 8)
      $error("gpm_port: width must be 1 to 8");

   // registers; narrow ports keep no bit7
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         data_r <= RST_DATA[W-1:0];
         dir_r <= RST_DIR[W-1:0];
         led_r <= RST_LED[W-1:0];
         meta_r <= '0;
         sync_r <= '0;
      end
      else if (ce)
      begin
         if (we_data)
            data_r <= wdata[W-1:0];
         if (we_dir)
            dir_r <= wdata[W-1:0];
         if (we_led && HAS_LED)
            led_r <= wdata[W-1:0];
         meta_r <= pin_in;
         sync_r <= meta_r;
      end
   end

   // read pin level for inputs, latch for outputs
   assign eff_dir = dir_r & ~force_in;
   assign rd_bits = (eff_dir & data_r) | (~eff_dir & sync_r);
   assign rd_data = 8'(rd_bits);
endmodule : gpm_port

// ===== gpm_pad_model.sv
// board side of one port: pad level from device drive or board level
`timescale 1ns/10ps
module gpm_pad_model
   import gpm_pkg::*;
(
   input gpm_drv_t drv,
   input wire logic [7:0] board,
   output logic [7:0] pad
);
   // a driven pad follows the device, a released one shows the board level
   assign pad = (drv.oe & drv.out) | (~drv.oe & board);
endmodule : gpm_pad_model

// ===== tb_top.sv
// self-checking bench for the gpio ports and pin multiplexing
`timescale 1ns/10ps
module tb_top
   import gpm_pkg::*;
;
   logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
   logic prot = 0, u0 = 1, u1 = 1, apf = 1, rpf = 0, spf = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata;
   logic pready, pslverr, u0rx, u1rx, lvd, ei0, ei1, irtx, er;
   logic [7:0] bd0 = 8'h3C, bd1 = 8'h7E, bd2 = 8'hE5, bd3 = 8'h7B;
   logic [7:0] bda = 8'h5A, pd0, pd1, pd2, pd3, pda, lcd_q, rd;
   logic [39:0] seg = 40'h020000000C;
   logic [6:0] key;
   logic [2:0] tmr;
   gpm_drv_t d0, d1, d2, d3, da;
   int miscompares = 0, checks = 0;

   // clock at 40 MHz
   always #12.5 pclk = ~pclk;

   // board pads
   gpm_pad_model m0 (.drv(d0), .board(bd0), .pad(pd0));
   gpm_pad_model m1 (.drv(d1), .board(bd1), .pad(pd1));
   gpm_pad_model m2 (.drv(d2), .board(bd2), .pad(pd2));
   gpm_pad_model m3 (.drv(d3), .board(bd3), .pad(pd3));
   gpm_pad_model ma (.drv(da), .board(bda), .pad(pda));

   gpm_top dut (
      .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .protect_release(prot), .p0_pin_in(pd0), .p1_pin_in(pd1[6:0]),
      .p2_pin_in(pd2), .p3_pin_in(pd3[6:0]), .pa_pin_in(pda),
      .lcd_seg_in(seg), .uart0_tx(u0), .uart1_tx(u1),
      .active_energy_pulse(apf), .reactive_energy_pulse(rpf),
      .apparent_energy_pulse(spf), .p0_drv_r(d0), .p1_drv_r(d1),
      .p2_drv_r(d2), .p3_drv_r(d3), .pa_drv_r(da),
      .lcd_segment_pin_select_r(lcd_q), .uart0_rx_r(u0rx),
      .uart1_rx_r(u1rx), .low_voltage_sense_input_r(lvd), .key_in_r(key),
      .ext_interrupt_zero_r(ei0), .ext_interrupt_one_r(ei1),
      .timer_in_r(tmr), .infrared_tx_select_r(irtx));

   task finish_test;
      $display("miscompares %0d checks %0d", miscompares, checks);
      if (miscompares == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : finish_test

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("Error at %0t: saw %h expected %h", $time, got, exp);
      end
   endtask : chk

   // one apb transfer, held until pready is sampled high
   task apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (n >= 50)
      begin
         chk(1'b0, 1'b1);
         finish_test;
      end
      rd = prdata[7:0];
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task rdc(input logic [7:0] idx, input logic [7:0] exp);
      apb(1'b0, idx, 8'h00);
      chk(rd, exp);
   endtask : rdc

   task t_reset;
      logic [7:0] lst [12];
      lst = '{IDX_P0_DIR, IDX_P1_DIR, IDX_P2_DIR, IDX_P3_DIR, IDX_PA_DIR,
         IDX_P0_LED, IDX_P1_LED, IDX_P3_LED, IDX_KEY_SEL, IDX_LCD_SEL,
         IDX_P02_SEL, IDX_P3_SEL};
      repeat (5) @(posedge pclk);
      chk(d0, 24'h000000);
      chk(d2.oe, 8'hE5);
      chk(d2.out[6], 1'b1);
      chk(lvd, 1'b0);
      chk({u0rx, u1rx}, 2'b00);
      foreach (lst[i])
         rdc(lst[i], 8'h00);
   endtask : t_reset

   task t_mux;
      apb(1'b1, IDX_LCD_SEL, 8'h01);
      rdc(IDX_LCD_SEL, 8'h00);
      prot <= 1'b1;
      apb(1'b1, IDX_LCD_SEL, 8'h01);
      apb(1'b1, IDX_P02_SEL, 8'hF1);
      apb(1'b1, IDX_P3_SEL, 8'hFF);
      rdc(IDX_P3_SEL, 8'h7E);
      repeat (5) @(posedge pclk);
      chk({da.oe, da.out[3:0]}, 12'h0FC);
      chk({d0.oe, d0.out[1:0]}, 10'h00E);
      chk(d2.oe, 8'h00);
      chk(lvd, 1'b1);
      chk({u0rx, u1rx}, 2'b11);
      chk(lcd_q, 8'h01);
      chk({ei0, ei1, tmr, irtx}, 6'h1F);
      apb(1'b1, IDX_LCD_SEL, 8'h00);
      apb(1'b1, IDX_P02_SEL, 8'hF0);
      apb(1'b1, IDX_P3_SEL, 8'h00);
      prot <= 1'b0;
   endtask : t_mux

   task t_dir;
      apb(1'b1, IDX_P0_DATA, 8'hA5);
      apb(1'b1, IDX_P0_DIR, 8'h0F);
      repeat (5) @(posedge pclk);
      chk({d0.oe, d0.out}, 16'h0FA5);
      rdc(IDX_P0_DATA, 8'h35);
      // latch loaded before the pins turn back to inputs
      apb(1'b1, IDX_P0_DATA, 8'h0C);
      apb(1'b1, IDX_P0_DIR, 8'h00);
      repeat (5) @(posedge pclk);
      rdc(IDX_P0_DATA, 8'h3C);
   endtask : t_dir

   task t_key;
      apb(1'b1, IDX_P1_DIR, 8'hFF);
      rdc(IDX_P1_DIR, 8'h7F);
      apb(1'b1, IDX_KEY_SEL, 8'h81);
      rdc(IDX_KEY_SEL, 8'h01);
      repeat (5) @(posedge pclk);
      chk(d1.oe, 8'h7E);
      chk(key, 7'h7E);
      // clock enable low freezes the keypad input path
      ce <= 1'b0;
      bd1 <= 8'h7F;
      repeat (5) @(posedge pclk);
      chk(key, 7'h7E);
      ce <= 1'b1;
      repeat (5) @(posedge pclk);
      chk(key, 7'h7F);
   endtask : t_key

   task t_led;
      apb(1'b1, IDX_P3_DIR, 8'h7F);
      apb(1'b1, IDX_P3_LED, 8'h7F);
      rdc(IDX_P3_LED, 8'h7F);
      repeat (3) @(posedge pclk);
      chk({d3.oe, d3.led}, 16'h7F7F);
      apb(1'b0, 8'hA8, 8'h00);
      chk(er, 1'b1);
   endtask : t_led

   // watchdog against a hung handshake
   initial
   begin
      repeat (20000) @(posedge pclk);
      miscompares++;
      finish_test;
   end

   initial
   begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_mux;
      t_dir;
      t_key;
      t_led;
      finish_test;
   end
endmodule : tb_top
